// File: pdm_pkg.sv
/*
  Constants, register map and types for the port D pin-sharing block.
  Assumes one APB slave window with 32-bit data and byte addresses.
*/
package pdm_pkg;

  localparam int PDM_PINS = 8;
  localparam int PDM_SHW  = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] PDM_OFF_FUNC = 8'h00;
  localparam logic [7:0] PDM_OFF_DIR  = 8'h04;
  localparam logic [7:0] PDM_OFF_DOUT = 8'h08;
  localparam logic [7:0] PDM_OFF_DIN  = 8'h0c;
  localparam logic [7:0] PDM_OFF_PULL = 8'h10;
  localparam logic [7:0] PDM_OFF_STAT = 8'h14;

  // ==========================================================
  // Reset values and fixed masks
  localparam logic [7:0] PDM_FUNC_RST = 8'h0f;
  localparam logic [7:0] PDM_DIR_RST  = 8'h00;
  localparam logic [7:0] PDM_DOUT_RST = 8'h00;
  localparam logic [7:0] PDM_PULL_RST = 8'hcf;
  localparam logic [7:0] PDM_PU_FORCE = 8'h0f;
  localparam logic [23:0] PDM_RD_PAD  = 24'h000000;

  // ==========================================================
  // Pin and field positions
  localparam int PDM_PIN_TDI  = 0;
  localparam int PDM_PIN_TDO  = 1;
  localparam int PDM_PIN_TCK  = 2;
  localparam int PDM_PIN_TMS  = 3;
  localparam int PDM_PIN_XCLK = 5;
  localparam int PDM_STAT_SHIFT = 0;
  localparam int PDM_STAT_XCLK  = 1;

  // ==========================================================
  // Test controller states
  typedef enum logic [15:0] {
    PDM_TLR  = 16'h0001, PDM_RTI  = 16'h0002, PDM_SDR  = 16'h0004,
    PDM_CDR  = 16'h0008, PDM_SHDR = 16'h0010, PDM_E1DR = 16'h0020,
    PDM_PDR  = 16'h0040, PDM_E2DR = 16'h0080, PDM_UDR  = 16'h0100,
    PDM_SIR  = 16'h0200, PDM_CIR  = 16'h0400, PDM_SHIR = 16'h0800,
    PDM_E1IR = 16'h1000, PDM_PIR  = 16'h2000, PDM_E2IR = 16'h4000,
    PDM_UIR  = 16'h8000
  } pdm_tap_t;

  // ==========================================================
  // State carriers
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pdm_pins_t;

  typedef struct packed {
    logic [7:0]  func;
    logic [7:0]  dir;
    logic [7:0]  dout;
    logic [7:0]  pull;
    logic [7:0]  in_s1;
    logic [7:0]  in_s2;
    logic        sh_s1;
    logic        sh_s2;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    pdm_pins_t   pins;
  } pdm_mst_t;

  typedef struct packed {
    pdm_tap_t          tap;
    logic [PDM_SHW-1:0] sh;
  } pdm_tck_t;

  typedef struct packed {
    logic tdo;
    logic oe;
  } pdm_neg_t;

endpackage

// File: pdm_probe.sv
/*
  Probe model that drives the test clock, mode select and data in.
  Assumes the pins are pulled up; clock and data in idle high between frames, mode select idles low.
*/
`timescale 1ns/1ps

module pdm_probe
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic oe_ok;

  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    oe_ok = 1'b0;
  end

  // ==========================================================
  // One clock; mode and data change while the clock is low
  task automatic pulse(input logic m, input logic d, output logic s);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #40;
    s = tdo;
    tck = 1'b1;
    #40;
  endtask

  // ==========================================================
  // Reset walk, enter shift-DR, shift 8 bits, return to idle
  task automatic frame(input logic [7:0] din, output logic [7:0] dout);
    logic       s;
    logic [8:0] hdr;
    hdr = 9'b001011111;
    oe_ok = 1'b1;
    for (int i = 0; i < 9; i++)
      pulse(hdr[i], 1'b1, s);
    for (int i = 0; i < 8; i++)
    begin
      pulse(i == 7, din[i], s);
      dout[i] = s;
      oe_ok &= tdo_oe;
    end
    pulse(1'b1, 1'b1, s);
    pulse(1'b0, 1'b1, s);
  endtask
endmodule

// File: pdm_top.sv
/*
  Port D pin sharing: function select, GPIO, pulls, external clock
  routing and the test port pins with a minimal test controller.
  Assumes pads resolve levels from PD_OUT/PD_OE/PD_PU, that TCK is
  the test clock pad and that APB runs on MCLK.
*/
`timescale 1ns/1ps

module pdm_top
(
  input  logic        MCLK,
  input  logic        ARST_N,
  input  logic        CLK_EN,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [7:0]  PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  logic        TCK,
  input  logic [7:0]  PD_IN,
  output logic [7:0]  PD_OUT,
  output logic [7:0]  PD_OE,
  output logic [7:0]  PD_PU,
  output logic        EXT_CLK
);

  pdm_pkg::pdm_mst_t m_q;
  pdm_pkg::pdm_mst_t m_d;
  pdm_pkg::pdm_tck_t t_q;
  pdm_pkg::pdm_tck_t t_d;
  pdm_pkg::pdm_neg_t n_q;
  pdm_pkg::pdm_neg_t n_d;

  logic access;
  logic done;
  logic wr_done;

  // ==========================================================
  // Address decode
  function automatic logic pdm_mapped(input logic [7:0] a);
    pdm_mapped = (a == pdm_pkg::PDM_OFF_FUNC) ||
                 (a == pdm_pkg::PDM_OFF_DIR)  ||
                 (a == pdm_pkg::PDM_OFF_DOUT) ||
                 (a == pdm_pkg::PDM_OFF_DIN)  ||
                 (a == pdm_pkg::PDM_OFF_PULL) ||
                 (a == pdm_pkg::PDM_OFF_STAT);
  endfunction

  function automatic logic pdm_shifting(input pdm_pkg::pdm_tap_t s);
    pdm_shifting = (s == pdm_pkg::PDM_SHDR) || (s == pdm_pkg::PDM_SHIR);
  endfunction

  assign access  = PSEL && PENABLE;
  assign done    = access && m_q.pready;
  assign wr_done = done && PWRITE && pdm_mapped(PADDR);

  // ==========================================================
  // System clock domain
  always_comb
  begin
    m_d = m_q;
    if (CLK_EN)
    begin
      m_d.in_s1 = PD_IN;
      m_d.in_s2 = m_q.in_s1;
      m_d.sh_s1 = n_q.oe;
      m_d.sh_s2 = m_q.sh_s1;
      // One wait state, answer raised by the slave itself
      m_d.pready  = access && !m_q.pready;
      m_d.pslverr = access && !m_q.pready && !pdm_mapped(PADDR);
      m_d.prdata  = 32'h00000000;
      if (access && !m_q.pready && !PWRITE)
      begin
        case (PADDR)
          pdm_pkg::PDM_OFF_FUNC:
            m_d.prdata = {pdm_pkg::PDM_RD_PAD, m_q.func};
          pdm_pkg::PDM_OFF_DIR:
            m_d.prdata = {pdm_pkg::PDM_RD_PAD, m_q.dir};
          pdm_pkg::PDM_OFF_DOUT:
            m_d.prdata = {pdm_pkg::PDM_RD_PAD, m_q.dout};
          pdm_pkg::PDM_OFF_DIN:
            m_d.prdata = {pdm_pkg::PDM_RD_PAD, m_q.in_s2};
          pdm_pkg::PDM_OFF_PULL:
            m_d.prdata = {pdm_pkg::PDM_RD_PAD, m_q.pull};
          pdm_pkg::PDM_OFF_STAT:
          begin
            m_d.prdata[pdm_pkg::PDM_STAT_SHIFT] = m_q.sh_s2;
            m_d.prdata[pdm_pkg::PDM_STAT_XCLK] =
              m_q.func[pdm_pkg::PDM_PIN_XCLK];
          end
          default:
            m_d.prdata = 32'h00000000;
        endcase
      end
      if (wr_done)
      begin
        case (PADDR)
          pdm_pkg::PDM_OFF_FUNC:
            m_d.func = PWDATA[7:0];
          pdm_pkg::PDM_OFF_DIR:
            m_d.dir = PWDATA[7:0];
          pdm_pkg::PDM_OFF_DOUT:
            m_d.dout = PWDATA[7:0];
          pdm_pkg::PDM_OFF_PULL:
            m_d.pull = PWDATA[7:0];
          default:
            m_d.dout = m_d.dout;
        endcase
      end
      // Alternate use takes the pin away from its direction bit
      m_d.pins.out = m_d.dout;
      m_d.pins.oe  = m_d.dir & ~m_d.func;
      // Test input pins keep their pull-up whatever software asks
      m_d.pins.pu  = m_d.pull |
                     (m_d.func & pdm_pkg::PDM_PU_FORCE);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      m_q         <= '0;
      m_q.func    <= pdm_pkg::PDM_FUNC_RST;
      m_q.dir     <= pdm_pkg::PDM_DIR_RST;
      m_q.dout    <= pdm_pkg::PDM_DOUT_RST;
      m_q.pull    <= pdm_pkg::PDM_PULL_RST;
      m_q.pins.pu <= pdm_pkg::PDM_PULL_RST;
    end
    else
    begin
      m_q <= m_d;
    end
  end

  // ==========================================================
  // Test clock domain: controller and shift path
  always_comb
  begin
    t_d = t_q;
    // Mode select and data in are pins timed to TCK itself
    case (t_q.tap)
      pdm_pkg::PDM_TLR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_TLR : pdm_pkg::PDM_RTI;
      pdm_pkg::PDM_RTI:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_SDR : pdm_pkg::PDM_RTI;
      pdm_pkg::PDM_SDR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_SIR : pdm_pkg::PDM_CDR;
      pdm_pkg::PDM_CDR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_E1DR : pdm_pkg::PDM_SHDR;
      pdm_pkg::PDM_SHDR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_E1DR : pdm_pkg::PDM_SHDR;
      pdm_pkg::PDM_E1DR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_UDR : pdm_pkg::PDM_PDR;
      pdm_pkg::PDM_PDR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_E2DR : pdm_pkg::PDM_PDR;
      pdm_pkg::PDM_E2DR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_UDR : pdm_pkg::PDM_SHDR;
      pdm_pkg::PDM_UDR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_SDR : pdm_pkg::PDM_RTI;
      pdm_pkg::PDM_SIR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_TLR : pdm_pkg::PDM_CIR;
      pdm_pkg::PDM_CIR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_E1IR : pdm_pkg::PDM_SHIR;
      pdm_pkg::PDM_SHIR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_E1IR : pdm_pkg::PDM_SHIR;
      pdm_pkg::PDM_E1IR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_UIR : pdm_pkg::PDM_PIR;
      pdm_pkg::PDM_PIR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_E2IR : pdm_pkg::PDM_PIR;
      pdm_pkg::PDM_E2IR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_UIR : pdm_pkg::PDM_SHIR;
      pdm_pkg::PDM_UIR:
        t_d.tap = PD_IN[3] ? pdm_pkg::PDM_SDR : pdm_pkg::PDM_RTI;
      default:
        t_d.tap = pdm_pkg::PDM_TLR;
    endcase
    if (pdm_shifting(t_q.tap))
    begin
      t_d.sh = {PD_IN[0], t_q.sh[pdm_pkg::PDM_SHW-1:1]};
    end
  end

  always_ff @(posedge TCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      t_q     <= '0;
      t_q.tap <= pdm_pkg::PDM_TLR;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  // Output side moves half a test clock later
  always_comb
  begin
    n_d     = n_q;
    n_d.tdo = t_q.sh[0];
    n_d.oe  = pdm_shifting(t_q.tap);
  end

  always_ff @(negedge TCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      n_q <= '0;
    end
    else
    begin
      n_q <= n_d;
    end
  end

  // ==========================================================
  // Pin outputs
  assign PD_OUT = {m_q.pins.out[7:2],
                   m_q.func[1] ? n_q.tdo : m_q.pins.out[1],
                   m_q.pins.out[0]};
  assign PD_OE  = {m_q.pins.oe[7:2],
                   m_q.func[1] ? n_q.oe : m_q.pins.oe[1],
                   m_q.pins.oe[0]};
  assign PD_PU  = m_q.pins.pu;
  assign EXT_CLK = PD_IN[5] && m_q.func[5];
  assign PRDATA  = m_q.prdata;
  assign PREADY  = m_q.pready;
  assign PSLVERR = m_q.pslverr;

  // ==========================================================
  // Checks
  property p_dir_write;
    @(posedge MCLK) disable iff (!ARST_N)
    (wr_done && CLK_EN && PADDR == pdm_pkg::PDM_OFF_DIR) |=>
      (PD_OE[7:2] == ($past(PWDATA[7:2]) & ~m_q.func[7:2]));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not reach pin enables");

  property p_rst_gpio;
    @(posedge MCLK) disable iff (!ARST_N)
    $rose(ARST_N) |-> (m_q.func[7:5] == 3'h0) && (PD_OE[7:5] == 3'h0);
  endproperty
  a_rst_gpio: assert property (p_rst_gpio)
    else $error("pins 5 to 7 not GPIO inputs after reset");

  property p_rst_test;
    @(posedge MCLK) disable iff (!ARST_N)
    $rose(ARST_N) |-> (m_q.func[3:0] == 4'hf) && (PD_PU[3:0] == 4'hf);
  endproperty
  a_rst_test: assert property (p_rst_test)
    else $error("test pins not selected after reset");

  property p_xclk;
    @(posedge MCLK) disable iff (!ARST_N)
    m_q.func[5] |-> (EXT_CLK == PD_IN[5]) && !PD_OE[5];
  endproperty
  a_xclk: assert property (p_xclk)
    else $error("pin 5 clock alternate not routed");

  property p_tdi_cap;
    @(posedge TCK) disable iff (!ARST_N)
    pdm_shifting(t_q.tap) |=> t_q.sh[pdm_pkg::PDM_SHW-1] == $past(PD_IN[0]);
  endproperty
  a_tdi_cap: assert property (p_tdi_cap)
    else $error("test data in not captured on rising test clock");

  property p_tdo_drive;
    @(posedge TCK) disable iff (!ARST_N)
    m_q.func[1] |-> (PD_OE[1] == pdm_shifting(t_q.tap)) &&
      (!PD_OE[1] || PD_OUT[1] == t_q.sh[0]);
  endproperty
  a_tdo_drive: assert property (p_tdo_drive)
    else $error("test data out driven outside shift states");

  sequence s_rti_to_shdr;
    (t_q.tap == pdm_pkg::PDM_RTI && PD_IN[3]) ##1 !PD_IN[3] ##1 !PD_IN[3];
  endsequence

  property p_tms_walk;
    @(posedge TCK) disable iff (!ARST_N)
    s_rti_to_shdr |=> t_q.tap == pdm_pkg::PDM_SHDR;
  endproperty
  a_tms_walk: assert property (p_tms_walk)
    else $error("mode select walk did not reach shift data");

  property p_tck_pull;
    @(posedge MCLK) disable iff (!ARST_N)
    m_q.func[2] && m_q.func[0] |-> PD_PU[2] && PD_PU[0] && !PD_OE[2];
  endproperty
  a_tck_pull: assert property (p_tck_pull)
    else $error("test clock or data pin lost its pull-up");

  property p_func_write;
    @(posedge MCLK) disable iff (!ARST_N)
    (wr_done && CLK_EN && PADDR == pdm_pkg::PDM_OFF_FUNC) |=>
      m_q.func == $past(PWDATA[7:0]);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("function select write lost");

  property p_dout_write;
    @(posedge MCLK) disable iff (!ARST_N)
    (wr_done && CLK_EN && PADDR == pdm_pkg::PDM_OFF_DOUT) |=>
      PD_OUT[7:2] == $past(PWDATA[7:2]);
  endproperty
  a_dout_write: assert property (p_dout_write)
    else $error("output data write did not reach pin values");

  property p_stat_sync;
    @(posedge MCLK) disable iff (!ARST_N)
    $past(CLK_EN) && $past(CLK_EN, 2) |-> m_q.sh_s2 == $past(n_q.oe, 2);
  endproperty
  a_stat_sync: assert property (p_stat_sync)
    else $error("shift status not passed across clocks");

  property p_tdo_fall;
    @(negedge TCK) disable iff (!ARST_N)
    m_q.func[1] && pdm_shifting(t_q.tap) |=> PD_OUT[1] == $past(t_q.sh[0]);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("test data out did not move on falling test clock");

  // Five high mode-select samples return the controller to reset
  sequence s_tms_high5;
    PD_IN[3] [*5];
  endsequence

  property p_tap_reset;
    @(posedge TCK) disable iff (!ARST_N)
    s_tms_high5 |=> t_q.tap == pdm_pkg::PDM_TLR;
  endproperty
  a_tap_reset: assert property (p_tap_reset)
    else $error("five high mode selects did not reach reset state");

endmodule

// File: test_port_d_pin_sharing_with_jtag.sv
/*
  Self-checking bench for the port D pin-sharing block.
  Assumes the probe model and the pdm package are compiled first.
*/
`timescale 1ns/1ps

module test_port_d_pin_sharing_with_jtag;
  logic        MCLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic        CLK_EN = 1'b1;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, EXT_CLK, tck, tms, tdi;
  logic [7:0]  PD_OUT, PD_OE, PD_PU, pad;
  logic [7:0]  ext = 8'h00;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #5 MCLK = ~MCLK;

  // ==========================================================
  // Pad levels; test pins come from the probe, pin 1 is pulled up
  assign pad = {(PD_OE[7:4] & PD_OUT[7:4]) | (~PD_OE[7:4] & ext[7:4]),
                tms, tck, PD_OE[1] ? PD_OUT[1] : 1'b1, tdi};

  pdm_top i_dut
  (
    .MCLK(MCLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TCK(tck),
    .PD_IN(pad), .PD_OUT(PD_OUT), .PD_OE(PD_OE), .PD_PU(PD_PU),
    .EXT_CLK(EXT_CLK)
  );

  pdm_probe i_probe
  (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(pad[1]), .tdo_oe(PD_OE[1])
  );

  // ==========================================================
  // Compare, bus and closing tasks
  task automatic chk32(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    chk32({24'h0, g}, {24'h0, e}, m);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1)
      @(posedge MCLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
    chk8({7'h0, e}, 8'h00, "write error");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(r, x, "read data");
    chk8({7'h0, e}, {7'h0, xe}, "read error");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdc(pdm_pkg::PDM_OFF_FUNC, 32'h0f, 1'b0);
    rdc(pdm_pkg::PDM_OFF_DIR, 32'h00, 1'b0);
    rdc(pdm_pkg::PDM_OFF_PULL, 32'hcf, 1'b0);
    chk8(PD_OE, 8'h00, "oe");
    chk8(PD_PU, 8'hcf, "pu");
    chk8({7'h0, EXT_CLK}, 8'h00, "xclk");
    $display("test reset done");
  endtask

  task automatic t_gpio();
    wr(pdm_pkg::PDM_OFF_DIR, 8'ha0);
    wr(pdm_pkg::PDM_OFF_DOUT, 8'hf0);
    ext <= 8'h10;
    repeat (4) @(posedge MCLK);
    chk8(PD_OE, 8'ha0, "gpio oe");
    chk8({PD_OUT[7:4], 4'h0}, 8'hf0, "gpio out");
    rdc(pdm_pkg::PDM_OFF_DIN, 32'hbf, 1'b0);
    rdc(pdm_pkg::PDM_OFF_DOUT, 32'hf0, 1'b0);
    wr(pdm_pkg::PDM_OFF_DIR, 8'h00);
    $display("test gpio done");
  endtask

  task automatic t_xclk();
    wr(pdm_pkg::PDM_OFF_FUNC, 8'h2f);
    ext[5] <= 1'b1;
    @(posedge MCLK);
    chk8({7'h0, EXT_CLK}, 8'h01, "xclk high");
    ext[5] <= 1'b0;
    @(posedge MCLK);
    chk8({7'h0, EXT_CLK}, 8'h00, "xclk low");
    rdc(pdm_pkg::PDM_OFF_STAT, 32'h02, 1'b0);
    wr(pdm_pkg::PDM_OFF_FUNC, 8'h0f);
    ext[5] <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk8({7'h0, EXT_CLK}, 8'h00, "xclk gpio");
    $display("test ext clock done");
  endtask

  task automatic t_err();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 8'h19, 32'h0, r, e);
    chk8({7'h0, e}, 8'h01, "unaligned write");
    rdc(8'h18, 32'h0, 1'b1);
    rdc(8'hfc, 32'h0, 1'b1);
    rdc(pdm_pkg::PDM_OFF_FUNC, 32'h0f, 1'b0);
    $display("test errors done");
  endtask

  task automatic t_pull();
    wr(pdm_pkg::PDM_OFF_PULL, 8'h00);
    wr(pdm_pkg::PDM_OFF_FUNC, 8'h00);
    @(posedge MCLK);
    chk8(PD_PU, 8'h00, "pu gpio");
    wr(pdm_pkg::PDM_OFF_FUNC, 8'h0f);
    @(posedge MCLK);
    chk8(PD_PU, 8'h0f, "pu test");
    wr(pdm_pkg::PDM_OFF_PULL, 8'hcf);
    $display("test pulls done");
  endtask

  task automatic t_freeze();
    CLK_EN <= 1'b0;
    fork
      wr(pdm_pkg::PDM_OFF_DOUT, 8'h55);
      begin
        repeat (6) @(posedge MCLK);
        chk8({7'h0, PREADY}, 8'h00, "frozen ready");
        CLK_EN <= 1'b1;
      end
    join
    rdc(pdm_pkg::PDM_OFF_DOUT, 32'h55, 1'b0);
    $display("test clock enable done");
  endtask

  task automatic t_tap();
    logic [7:0] d;
    #3;
    fork
      i_probe.frame(8'ha5, d);
      begin
        repeat (110) @(posedge MCLK);
        rdc(pdm_pkg::PDM_OFF_STAT, 32'h01, 1'b0);
      end
    join
    chk8(d, 8'h00, "tap first");
    i_probe.frame(8'h3c, d);
    chk8(d, 8'ha5, "tap shift");
    chk8({7'h0, i_probe.oe_ok}, 8'h01, "tdo driven");
    chk8({7'h0, PD_OE[1]}, 8'h00, "tdo released");
    @(posedge MCLK);
    $display("test test port done");
  endtask

  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (10) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_gpio();
    t_xclk();
    t_err();
    t_pull();
    t_freeze();
    t_tap();
    report_and_stop();
  end
endmodule
